// ---- core/dhl_pkg.sv ----
// Constants and carrier types for the drive health and log command interpreter
package dhl_pkg;
   // Command codes
   localparam logic [7:0]  CMD_HEALTH      = 8'hB0;
   localparam logic [7:0]  CMD_READ_LOG    = 8'h2F;
   // Health subcommands and key word
   localparam logic [7:0]  SUB_STATUS      = 8'hDA;
   localparam logic [7:0]  SUB_AUTO_OFF    = 8'hDB;
   localparam logic [15:0] HEALTH_KEY      = 16'hC24F;
   localparam logic [15:0] STATUS_GOOD     = 16'hC24F;
   localparam logic [15:0] STATUS_FAIL     = 16'h2CF4;
   localparam logic [15:0] AUTO_OFF_CLEAR  = 16'h0000;
   localparam logic [15:0] AUTO_OFF_SET    = 16'h00F8;
   // Automatic collection period in power-on hours
   localparam logic [4:0]  COLLECT_HOURS   = 5'h18;
   // Log map
   localparam logic [7:0]  LOG_DIR         = 8'h00;
   localparam logic [7:0]  LOG_EXT_ERR     = 8'h03;
   localparam logic [7:0]  LOG_EXT_TEST    = 8'h07;
   localparam logic [7:0]  LOG_HOST_FIRST  = 8'h80;
   localparam logic [7:0]  LOG_HOST_LAST   = 8'h9F;
   localparam logic [15:0] DIR_SECTORS     = 16'h0001;
   localparam logic [15:0] EXT_ERR_SECTORS = 16'h0040;
   localparam logic [15:0] EXT_TEST_SECT   = 16'h0001;
   localparam logic [15:0] HOST_SECTORS    = 16'h0010;
   localparam logic [15:0] LOG_VERSION     = 16'h0001;
   localparam logic [7:0]  LAST_WORD       = 8'hFF;
   // Memory and buffer shape
   localparam int          MEM_AW          = 17;
   localparam int          FIFO_W          = 16;
   localparam int          FIFO_D          = 8;

   // Task-file contents latched with the command write
   typedef struct packed {
      logic [7:0]  cmd_code;   // Command register
      logic [7:0]  subcommand; // subcommand_reg
      logic [15:0] xfer_len;   // transfer_length_reg, previous:current
      logic [15:0] track_word; // track_word_reg
      logic [7:0]  log_addr;   // start_index_reg current byte
      logic [15:0] sector_off; // Mid address, previous:current
   } dhl_taskfile_s;

   // Status seen by the host
   typedef struct packed {
      logic busy;  // Device busy
      logic err;   // Aborted command
      logic xfer;  // Log read stream open
   } dhl_status_s;
endpackage : dhl_pkg

// ---- core/dhl_fifo.sv ----
// Word FIFO with a registered head between the log reader and the host
`timescale 1ns/1ps
module dhl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,       // Clock
   input  wire logic             rst_n,     // Async reset, low
   input  wire logic             in_valid,  // Word offered
   input  wire logic [WIDTH-1:0] in_data,   // Offered word
   output      logic             in_ready,  // Room for a word
   output      logic             out_valid, // Head word valid
   output      logic [WIDTH-1:0] out_data,  // Head word
   input  wire logic             out_ready  // Consumer takes head
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // Storage
   logic [AW-1:0]    wr_ptr;        // Write index
   logic [AW-1:0]    rd_ptr;        // Read index
   logic [AW:0]      count;         // Stored words
   logic             push;          // Accepted input
   logic             load;          // Head refill

   assign in_ready = (count < (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign load     = (count != '0) && (!out_valid || out_ready);

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (load) rd_ptr <= rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // Registered head so the host sees a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (load) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : dhl_fifo

// ---- core/dhl_log_mem.sv ----
// Storage for the host-defined logs, registered read port
`timescale 1ns/1ps
module dhl_log_mem (
   input  wire logic                       clk,     // Clock
   input  wire logic                       wr_en,   // Write strobe
   input  wire logic [dhl_pkg::MEM_AW-1:0] wr_addr, // Write word address
   input  wire logic [15:0]                wr_data, // Write word
   input  wire logic                       rd_en,   // Read strobe
   input  wire logic [dhl_pkg::MEM_AW-1:0] rd_addr, // Read word address
   output      logic [15:0]                rd_data  // Word, one cycle later
);
   // 32 logs of 16 sectors of 256 words; no reset, contents are data
   logic [15:0] mem [2**dhl_pkg::MEM_AW];

   // Write port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : dhl_log_mem

// ---- core/dhl_top.sv ----
// Health subcommand and extended log read interpreter
// Contract
// R1: host sends B0h, key C24Fh, DAh or DBh
// R2: no failure predicted: track bytes 4Fh, C2h
// R3: failure predicted: track bytes F4h, 2Ch
// R4: status return: busy, save parameters, then evaluate
// R5: auto off-line length zero disables collection
// R6: auto off-line length F8h enables collection
// R7: other non-zero lengths are vendor choice
// R8: saving may still occur when disabled
// R9: enabled collection runs every 24 hours
// R10: interrupt for each transferred data block
// R11: read starts at offset, 16-bit length
// R12: host loads log address and offset first
// R13: log map: directory, error, test, host logs
// R14: logs 01h 02h 06h 09h abort
// R15: directory one sector, counts low byte first
// R16: directory version word is 0001h
// R17: host logs sixteen sectors, directory says 10h
// R18: health done: clear busy, then interrupt
// R19: health disabled: abort every health subcommand
// R20: reserved log aborts, reserved fields untouched
// R21: unlisted task-file registers keep host values
`timescale 1ns/1ps
module dhl_top (
   input  wire logic                       clk,           // 200 MHz clock
   input  wire logic                       rst_n,         // Async reset, low
   input  wire logic                       cmd_stb,       // Command register written
   input  wire dhl_pkg::dhl_taskfile_s     taskfile,      // Task file at command write
   input  wire logic                       health_on,     // Health monitoring enabled
   input  wire logic                       fail_predict,  // Failure predicted
   input  wire logic                       save_done,     // Non-volatile save finished
   input  wire logic                       hour_tick,     // One pulse per powered hour
   input  wire logic                       hlog_wr,       // Host log word write
   input  wire logic [dhl_pkg::MEM_AW-1:0] hlog_wr_addr,  // Host log word address
   input  wire logic [15:0]                hlog_wr_data,  // Host log word
   input  wire logic                       data_ready,    // Host takes a data word
   output      logic                       data_valid,    // Data word offered
   output      logic [15:0]                data_word,     // Data word, low byte first
   output      dhl_pkg::dhl_status_s       status,        // Busy, error, stream
   output      logic [15:0]                track_word_out,// track_word_reg result
   output      logic                       intrq,         // Interrupt pulse
   output      logic                       auto_off_en,   // Automatic collection on
   output      logic                       save_req,      // Save parameters pulse
   output      logic                       collect_req    // Collection pass pulse
);
   typedef enum {
      ST_IDLE, ST_ABORT, ST_SAVE, ST_EVAL, ST_DONE, ST_IRQ, ST_RD_ADDR, ST_RD_PUSH, ST_RD_END
   } dhl_state_e;

   dhl_state_e              state;        // Sequencer state
   dhl_pkg::dhl_taskfile_s  tf;           // Latched task file
   logic [15:0]             sector;       // Sector being sent
   logic [15:0]             remaining;    // Sectors still to send
   logic [7:0]              word_idx;     // Word within sector
   logic [4:0]              hour_cnt;     // Hours since last pass
   logic                    health_cmd;   // Command is a health one
   logic                    health_ok;    // Health command may run
   logic                    read_cmd;     // Command is log read
   logic [15:0]             req_size;     // Size of requested log
   logic [16:0]             req_end;      // Offset plus count
   logic                    read_ok;      // Log read may run
   logic                    fifo_ready;   // FIFO has room
   logic                    push;         // Word pushed this cycle
   logic [15:0]             push_word;    // Word being pushed
   logic [15:0]             mem_word;     // Host log word
   logic [dhl_pkg::MEM_AW-1:0] mem_addr;  // Host log read address
   logic                    host_log;     // Current log is host-defined
   logic [3:0]              pending;      // Words pushed, not yet taken by host
   logic                    fifo_empty;   // Nothing left for the host

   // Sector count of a log; zero marks a log this command may not read
   function automatic logic [15:0] log_size(input logic [7:0] addr);
      logic [15:0] size;
      size = '0;
      // R13 log map
      if (addr == dhl_pkg::LOG_DIR) size = dhl_pkg::DIR_SECTORS;
      else if (addr == dhl_pkg::LOG_EXT_ERR) size = dhl_pkg::EXT_ERR_SECTORS;
      else if (addr == dhl_pkg::LOG_EXT_TEST) size = dhl_pkg::EXT_TEST_SECT;
      // R17 sixteen-sector host logs
      else if (addr >= dhl_pkg::LOG_HOST_FIRST && addr <= dhl_pkg::LOG_HOST_LAST) begin
         size = dhl_pkg::HOST_SECTORS;
      end
      return size;
   endfunction : log_size

   // Command decode on the incoming task file
   assign health_cmd = (taskfile.cmd_code == dhl_pkg::CMD_HEALTH);
   // R19 abort when disabled or key missing
   assign health_ok  = health_on && (taskfile.track_word == dhl_pkg::HEALTH_KEY);
   assign read_cmd   = (taskfile.cmd_code == dhl_pkg::CMD_READ_LOG);
   assign req_size   = log_size(taskfile.log_addr);
   assign req_end    = {1'b0, taskfile.sector_off} + {1'b0, taskfile.xfer_len};
   // R14 unlisted logs have size zero, so they abort
   // R20 reserved addresses abort too
   assign read_ok    = (req_size != '0) && (taskfile.xfer_len != '0)
                       && (req_end <= {1'b0, req_size});

   // Main sequencer; one command at a time, strobes while busy are ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_stb && health_cmd) begin
                  if (!health_ok) state <= ST_ABORT;
                  else if (taskfile.subcommand == dhl_pkg::SUB_STATUS) state <= ST_SAVE;
                  else if (taskfile.subcommand == dhl_pkg::SUB_AUTO_OFF) state <= ST_DONE;
                  else state <= ST_ABORT;
               end else if (cmd_stb && read_cmd) begin
                  state <= read_ok ? ST_RD_ADDR : ST_ABORT;
               end else if (cmd_stb) begin
                  state <= ST_ABORT;
               end
            end
            ST_ABORT: state <= ST_DONE;
            // R4 evaluate only after the save ends
            ST_SAVE:  if (save_done) state <= ST_EVAL;
            ST_EVAL:  state <= ST_DONE;
            ST_DONE:  state <= ST_IRQ;
            ST_IRQ:   state <= ST_IDLE;
            ST_RD_ADDR: state <= ST_RD_PUSH;
            ST_RD_PUSH: begin
               if (fifo_ready) begin
                  if (word_idx != dhl_pkg::LAST_WORD) state <= ST_RD_ADDR;
                  else if (remaining == 16'h0001) state <= ST_RD_END;
                  else state <= ST_RD_ADDR;
               end
            end
            // Stream closes once the host has drained every word
            ST_RD_END: if (!data_valid && fifo_empty) state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Task file latch and read position
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tf        <= '0;
         sector    <= '0;
         remaining <= '0;
         word_idx  <= '0;
      end else if (state == ST_IDLE && cmd_stb) begin
         tf        <= taskfile;
         // R11 start at the requested offset
         sector    <= taskfile.sector_off;
         remaining <= taskfile.xfer_len;
         word_idx  <= '0;
      end else if (push) begin
         word_idx <= word_idx + 8'h01;
         if (word_idx == dhl_pkg::LAST_WORD) begin
            sector    <= sector + 16'h0001;
            remaining <= remaining - 16'h0001;
         end
      end
   end

   // Busy and error flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         if (state == ST_IDLE && cmd_stb) begin
            status.busy <= 1'b1;
            status.err  <= 1'b0;
            status.xfer <= 1'b0;
         end
         if (state == ST_ABORT) status.err <= 1'b1;
         // R18 busy falls one cycle ahead of the interrupt
         if (state == ST_DONE) status.busy <= 1'b0;
         // Busy drops once the stream is open; data flow shows progress
         if (state == ST_RD_ADDR) begin
            status.busy <= 1'b0;
            status.xfer <= 1'b1;
         end
         if (state == ST_RD_END && !data_valid && fifo_empty) status.xfer <= 1'b0;
      end
   end

   // Interrupt pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intrq <= 1'b0;
      end else begin
         // R10 one interrupt at the start of each block
         // R18 completion interrupt after busy cleared
         intrq <= (state == ST_IRQ) || (state == ST_RD_ADDR && word_idx == 8'h00);
      end
   end

   // Health result in the track word; untouched task-file fields are not driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         track_word_out <= dhl_pkg::STATUS_GOOD;
      end else if (state == ST_IDLE && cmd_stb) begin
         // R21 echo host value unless a result replaces it
         track_word_out <= taskfile.track_word;
      end else if (state == ST_EVAL) begin
         // R2 good status word
         // R3 failing status word
         track_word_out <= fail_predict ? dhl_pkg::STATUS_FAIL : dhl_pkg::STATUS_GOOD;
      end
   end

   // Automatic off-line control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_off_en <= 1'b0;
      end else if (state == ST_IDLE && cmd_stb && health_cmd && health_ok
                   && taskfile.subcommand == dhl_pkg::SUB_AUTO_OFF) begin
         // R5 zero disables
         if (taskfile.xfer_len == dhl_pkg::AUTO_OFF_CLEAR) auto_off_en <= 1'b0;
         // R6 F8h enables
         else if (taskfile.xfer_len == dhl_pkg::AUTO_OFF_SET) auto_off_en <= 1'b1;
         // R7 other values leave the setting alone
      end else if (!health_on) begin
         // Turning monitoring off stops every health timer
         auto_off_en <= 1'b0;
      end
   end

   // Hour counter and collection pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hour_cnt    <= '0;
         collect_req <= 1'b0;
      end else begin
         collect_req <= 1'b0;
         if (!auto_off_en) begin
            hour_cnt <= '0;
         end else if (hour_tick) begin
            // R9 one pass per 24 powered hours
            if (hour_cnt == dhl_pkg::COLLECT_HOURS - 5'h01) begin
               hour_cnt    <= '0;
               collect_req <= 1'b1;
            end else begin
               hour_cnt <= hour_cnt + 5'h01;
            end
         end
      end
   end

   // Save request on status return
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         save_req <= 1'b0;
      end else begin
         // R4 save parameters while busy
         // R8 collection pass also saves
         save_req <= (state == ST_IDLE && cmd_stb && health_cmd && health_ok
                      && taskfile.subcommand == dhl_pkg::SUB_STATUS) || collect_req;
      end
   end

   // Word source: directory built on the fly, host logs from memory
   assign host_log = (tf.log_addr >= dhl_pkg::LOG_HOST_FIRST);
   assign mem_addr = {tf.log_addr[4:0], sector[3:0], word_idx};
   always_comb begin
      push_word = '0;
      if (tf.log_addr == dhl_pkg::LOG_DIR) begin
         // R15 word n holds count of log n
         // R16 word zero is the version
         if (word_idx == 8'h00) push_word = dhl_pkg::LOG_VERSION;
         else push_word = log_size(word_idx);
      end else if (host_log) begin
         push_word = mem_word;
      end
      // Error and self-test contents are kept elsewhere; zeros stand in
   end
   assign push = (state == ST_RD_PUSH) && fifo_ready;

   // Words in flight; the FIFO room flag alone cannot tell empty from part full
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= '0;
      end else begin
         pending <= pending + 4'(push) - 4'(data_valid && data_ready);
      end
   end
   assign fifo_empty = (pending == 4'h0);

   dhl_log_mem u_mem (
      .clk     (clk),
      .wr_en   (hlog_wr),
      .wr_addr (hlog_wr_addr),
      .wr_data (hlog_wr_data),
      .rd_en   (state == ST_RD_ADDR),
      .rd_addr (mem_addr),
      .rd_data (mem_word)
   );

   // Back-pressure from the host stalls the sequencer in ST_RD_PUSH
   dhl_fifo #(.WIDTH(dhl_pkg::FIFO_W), .DEPTH(dhl_pkg::FIFO_D)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (state == ST_RD_PUSH),
      .in_data   (push_word),
      .in_ready  (fifo_ready),
      .out_valid (data_valid),
      .out_data  (data_word),
      .out_ready (data_ready)
   );

   // Checks
   good_status_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
      state == ST_EVAL && !fail_predict |=> track_word_out == 16'hC24F)
      else $error("good status word wrong");
   fail_status_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      state == ST_EVAL && fail_predict |=> track_word_out == 16'h2CF4)
      else $error("failure status word wrong");
   save_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
      state == ST_SAVE |-> status.busy && !$past(state == ST_EVAL))
      else $error("save not under busy");
   off_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
      state == ST_IDLE && cmd_stb && health_cmd && health_ok
      && taskfile.subcommand == 8'hDB && taskfile.xfer_len == 16'h0000 |=> !auto_off_en)
      else $error("auto off-line not disabled");
   off_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
      state == ST_IDLE && cmd_stb && health_cmd && health_ok
      && taskfile.subcommand == 8'hDB && taskfile.xfer_len == 16'h00F8 |=> auto_off_en)
      else $error("auto off-line not enabled");
   day_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
      collect_req |-> $past(hour_cnt) == 5'h17 && $past(hour_tick) && $past(auto_off_en))
      else $error("collection pass off schedule");
   block_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
      state == ST_RD_ADDR && word_idx == 8'h00 |=> intrq)
      else $error("no interrupt for data block");
   bad_log_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
      state == ST_IDLE && cmd_stb && read_cmd && taskfile.log_addr == 8'h09
      |-> ##2 status.err ##2 intrq)
      else $error("forbidden log not aborted");
   dir_version_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
      push && tf.log_addr == 8'h00 && word_idx == 8'h00 |-> push_word == 16'h0001)
      else $error("directory version wrong");
   host_size_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
      push && tf.log_addr == 8'h00 && word_idx == 8'h80 |-> push_word == 16'h0010)
      else $error("host log size wrong");
   irq_order_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
      state == ST_DONE |=> !status.busy ##1 intrq && !status.busy)
      else $error("interrupt before busy cleared");
   off_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
      state == ST_IDLE && cmd_stb && health_cmd && !health_on |=> state == ST_ABORT)
      else $error("disabled health command not aborted");

   status_run_c: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_EVAL ##1 state == ST_DONE);
   auto_on_c:    cover property (@(posedge clk) disable iff (!rst_n) $rose(auto_off_en));
   two_block_c:  cover property (@(posedge clk) disable iff (!rst_n)
      intrq && status.xfer ##[1:1000] intrq && status.xfer);
endmodule : dhl_top

// ---- bench/dhl_host_model.sv ----
// Host side model that takes streamed log words
`timescale 1ns/1ps
module dhl_host_model (
   input  wire logic clk,        // Clock
   input  wire logic rst_n,      // Async reset, low
   input  wire logic stall,      // Hold off next cycle
   output      logic data_ready  // Word taken when high
);
   // Ready moves just after the edge, so a slow host stalls the stream
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) data_ready <= 1'b0;
      else data_ready <= #1 !stall;
   end
endmodule : dhl_host_model

// ---- bench/dhl_top_tb.sv ----
// Self-checking bench for the health and log interpreter
`timescale 1ns/1ps
module dhl_top_tb;
   logic clk, rst_n, cmd_stb, health_on, fail_predict, save_done, hour_tick;   // Controls
   logic hlog_wr, stall, data_ready, data_valid, intrq, auto_off_en, save_req; // Strobes
   logic collect_req;                       // Collection pulse
   logic [dhl_pkg::MEM_AW-1:0] hlog_wr_addr; // Host log address
   logic [15:0] hlog_wr_data, data_word, track_word_out; // Words
   dhl_pkg::dhl_taskfile_s taskfile;        // Task file image
   dhl_pkg::dhl_status_s   status;          // Busy, error, stream
   logic [15:0] q[$];                       // Words taken by host
   logic [15:0] exp_w[512];                 // Written host log words
   logic [7:0]  bad_logs[5] = '{8'h01, 8'h02, 8'h06, 8'h09, 8'h04}; // Aborting logs
   logic [31:0] rnd = 32'd87106;            // Random state
   int bad_count = 0, num_checks = 0, icnt = 0, ccnt = 0, scnt = 0, i;

   dhl_top dhl_top_inst (.clk(clk), .rst_n(rst_n), .cmd_stb(cmd_stb), .taskfile(taskfile),
      .health_on(health_on), .fail_predict(fail_predict), .save_done(save_done),
      .hour_tick(hour_tick), .hlog_wr(hlog_wr), .hlog_wr_addr(hlog_wr_addr),
      .hlog_wr_data(hlog_wr_data), .data_ready(data_ready), .data_valid(data_valid),
      .data_word(data_word), .status(status), .track_word_out(track_word_out),
      .intrq(intrq), .auto_off_en(auto_off_en), .save_req(save_req),
      .collect_req(collect_req));
   dhl_host_model dhl_host_model_inst (.clk(clk), .rst_n(rst_n), .stall(stall),
      .data_ready(data_ready));

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Directory word n is the size of log n, word 0 the version
   function automatic logic [15:0] dir_word(int n);
      if (n == 0) return 16'h0001;
      if (n == 3) return 16'h0040;
      if (n == 7) return 16'h0001;
      if (n >= 128 && n <= 159) return 16'h0010;
      return 16'h0000;
   endfunction : dir_word

   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic stop_test;
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // Issue one command and wait, bounded, until idle again
   task automatic cmd(logic [7:0] c, logic [7:0] sub, logic [15:0] len, logic [15:0] tw,
                      logic [7:0] la, logic [15:0] off);
      int k;
      q = {};
      icnt = 0;
      taskfile = '{c, sub, len, tw, la, off};
      cmd_stb = 1'b1;
      @(posedge clk) #1 cmd_stb = 1'b0;
      for (k = 0; k < 9000; k++) begin
         @(posedge clk) #1;
         if (k > 1 && !status.busy && !status.xfer) break;
      end
      if (k == 9000) bad_count++;
      repeat (2) @(posedge clk);
      #1;
   endtask : cmd

   task automatic tick(int n);
      repeat (n) begin
         hour_tick = 1'b1;
         @(posedge clk) #1 hour_tick = 1'b0;
         @(posedge clk) #1;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask : tick

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Random stalls from the host; taken words and pulses are counted here
   always @(posedge clk) begin
      rnd = lfsr(rnd);
      stall <= #1 rnd[0] & rnd[1];
      save_done <= #1 save_req;
      if (data_valid && data_ready) q.push_back(data_word);
      if (intrq) icnt++;
      if (collect_req) ccnt++;
      if (save_req) scnt++;
   end

   // Watchdog well beyond the expected run
   initial begin
      #400000;
      bad_count++;
      stop_test;
   end

   initial begin
      {rst_n, cmd_stb, fail_predict, save_done, hour_tick, hlog_wr, stall} = '0;
      health_on = 1'b1;
      taskfile = '0;
      hlog_wr_addr = '0;
      hlog_wr_data = '0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      for (i = 0; i < 2; i++) begin
         fail_predict = i[0];
         cmd(8'hB0, 8'hDA, 16'h0, 16'hC24F, 8'h0, 16'h0);
         chk("track", i ? 16'h2CF4 : 16'hC24F, track_word_out);
         chk("intrq", 16'd1, 16'(icnt));
      end
      chk("saves", 16'd2, 16'(scnt));
      cmd(8'hB0, 8'hDB, 16'h00F8, 16'hC24F, 8'h0, 16'h0);
      chk("auto_on", 16'd1, 16'(auto_off_en));
      cmd(8'hB0, 8'hDB, 16'h0001, 16'hC24F, 8'h0, 16'h0);
      chk("auto_keep", 16'd1, 16'(auto_off_en));
      tick(23);
      chk("collect", 16'd0, 16'(ccnt));
      tick(1);
      chk("collect", 16'd1, 16'(ccnt));
      chk("saves", 16'd3, 16'(scnt));
      cmd(8'hB0, 8'hDB, 16'h0000, 16'hC24F, 8'h0, 16'h0);
      chk("auto_on", 16'd0, 16'(auto_off_en));
      tick(24);
      chk("collect", 16'd1, 16'(ccnt));
      health_on = 1'b0;
      cmd(8'hB0, 8'hDA, 16'h0, 16'hC24F, 8'h0, 16'h0);
      chk("abort", 16'd1, 16'(status.err));
      health_on = 1'b1;
      cmd(8'h2F, 8'h0, 16'h1, 16'h0, 8'h00, 16'h0);
      chk("dir_len", 16'd256, 16'(q.size()));
      for (i = 0; i < 256; i++) chk("dir", dir_word(i), q[i]);
      chk("blocks", 16'd1, 16'(icnt));
      foreach (bad_logs[j]) begin
         cmd(8'h2F, 8'h0, 16'h1, 16'h0, bad_logs[j], 16'h0);
         chk("abort", 16'd1, 16'(status.err));
         chk("no_data", 16'd0, 16'(q.size()));
      end
      for (i = 0; i < 512; i++) begin
         exp_w[i] = rnd[15:0];
         hlog_wr = 1'b1;
         hlog_wr_addr = {5'd1, 4'(3 + i / 256), 8'(i)};
         hlog_wr_data = exp_w[i];
         @(posedge clk) #1;
      end
      hlog_wr = 1'b0;
      cmd(8'h2F, 8'h0, 16'h2, 16'h0, 8'h81, 16'h3);
      for (i = 0; i < 512; i++) chk("hlog", exp_w[i], q[i]);
      chk("blocks", 16'd2, 16'(icnt));
      cmd(8'h2F, 8'h0, 16'h2, 16'h0, 8'h81, 16'hF);
      chk("past_end", 16'd1, 16'(status.err));
      cmd(8'hB0, 8'hDA, 16'h0, 16'h1234, 8'h0, 16'h0);
      chk("key_abort", 16'd1, 16'(status.err));
      chk("echo", 16'h1234, track_word_out);
      stop_test;
   end
endmodule : dhl_top_tb
